// ===== host_port_map.vh
/*
 * constants for the byte-wide host register port: bus widths,
 * the small register window reached through the port, and reset values.
 * assumes it is included by its bare name from the design files.
 */
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH

// ****************************************
// widths
// ****************************************
`define HP_DATA_W 8
`define HP_ADDR_W 9

// ****************************************
// register window
// ****************************************
`define HP_CFG_WORDS 256
`define HP_CFG_IDX_W 8
`define HP_ADDR_IRQ_STAT 9'h100
`define HP_ADDR_IRQ_MASK 9'h101
`define HP_ADDR_TX_FIFO 9'h102
`define HP_ADDR_RX_FIFO 9'h103
`define HP_ADDR_FIFO_STAT 9'h104
`define HP_BYTE_RST 8'h00
`define HP_READ_UNMAPPED 8'h00

// ****************************************
// irq status bits
// ****************************************
`define HP_IRQ_TX_DONE 0
`define HP_IRQ_RX_AVAIL 1
`define HP_IRQ_EXT 2

// ****************************************
// data status bits
// ****************************************
`define HP_STAT_TX_BUSY 0
`define HP_STAT_RX_FULL 1

`endif

// ===== strobe_sync.v
/*
 * two-flop synchroniser for one host control line plus an edge flag.
 * assumes the line is stable for at least two clock edges per level.
 */
`timescale 1ns/1ps
`default_nettype none
module strobe_sync #(
  parameter RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // line
  input wire line_in,
  output wire line_sync,
  output wire fell
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RESET_LEVEL;
      sync_q <= RESET_LEVEL;
      prev_q <= RESET_LEVEL;
    end else begin
      meta_q <= line_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign line_sync = sync_q;
  assign fell = prev_q & ~sync_q;
endmodule
`default_nettype wire

// ===== byte_host_register_port.v
/*
 * byte-wide host port: synchronises select and strobes, performs one write
 * per write assertion, drives read data, holds a config byte array, an irq
 * status/mask pair and a one-byte data path each way to the packet engine.
 * assumes ref_clk is the device clock and the host holds each strobe level
 * for at least three ref_clk periods.
 */
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.vh"
module byte_host_register_port #(
  parameter DATA_W = `HP_DATA_W,
  parameter ADDR_W = `HP_ADDR_W
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // host pins
  input wire [ADDR_W-1:0] host_addr_bus,
  input wire [DATA_W-1:0] host_data_bus_in,
  output reg [DATA_W-1:0] host_data_bus_out,
  output wire host_data_bus_oe,
  input wire host_select_n,
  input wire host_write_strobe_n,
  input wire host_read_strobe_n,
  output wire host_irq_n_out,
  output wire host_irq_n_oe,
  // packet data path clocked on ref_clk, towards the link engine
  output reg [DATA_W-1:0] tx_byte,
  output reg tx_valid,
  input wire tx_ready,
  input wire [DATA_W-1:0] rx_byte,
  input wire rx_valid,
  output wire rx_ready,
  // other interrupt sources inside the device
  input wire ext_irq
);
  // ****************************************
  // synchronisers
  // ****************************************
  wire sel_s;
  wire wr_s;
  wire rd_s;
  wire wr_fell;

  strobe_sync #(.RESET_LEVEL(1'b1)) u_sel (
    .ref_clk(ref_clk), .nrst(nrst), .line_in(host_select_n),
    .line_sync(sel_s), .fell()
  );
  strobe_sync #(.RESET_LEVEL(1'b1)) u_wr (
    .ref_clk(ref_clk), .nrst(nrst), .line_in(host_write_strobe_n),
    .line_sync(wr_s), .fell(wr_fell)
  );
  strobe_sync #(.RESET_LEVEL(1'b1)) u_rd (
    .ref_clk(ref_clk), .nrst(nrst), .line_in(host_read_strobe_n),
    .line_sync(rd_s), .fell()
  );

  // ****************************************
  // access decode
  // ****************************************
  // address and data are sampled after the strobe has passed the
  // synchroniser, so the host must hold them for the whole strobe
  wire wr_pulse = wr_fell & ~sel_s;
  // write wins whenever both strobes are low
  wire rd_active = ~sel_s & ~rd_s & wr_s;

  function is_addr;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  wire in_cfg = ~host_addr_bus[ADDR_W-1];
  wire [`HP_CFG_IDX_W-1:0] cfg_idx = host_addr_bus[`HP_CFG_IDX_W-1:0];

  // ****************************************
  // registers
  // ****************************************
  reg [DATA_W-1:0] cfg_mem [0:`HP_CFG_WORDS-1];
  reg [DATA_W-1:0] irq_stat_q;
  reg [DATA_W-1:0] irq_mask_q;
  reg [DATA_W-1:0] rx_hold_q;
  reg rx_full_q;
  reg rd_prev_q;
  reg tx_valid_prev_q;
  integer i;

  wire rx_take = rx_valid & ~rx_full_q;
  wire rd_start = rd_active & ~rd_prev_q;
  wire rx_pop = rd_start & is_addr(host_addr_bus, `HP_ADDR_RX_FIFO);
  // a hand-off is reported when valid drops, so a ready held high
  // still flags each byte exactly once
  wire tx_done = tx_valid_prev_q & ~tx_valid;
  assign rx_ready = ~rx_full_q;

  reg [DATA_W-1:0] irq_set_d;
  always @* begin
    irq_set_d = {DATA_W{1'b0}};
    irq_set_d[`HP_IRQ_TX_DONE] = tx_done;
    irq_set_d[`HP_IRQ_RX_AVAIL] = rx_take;
    irq_set_d[`HP_IRQ_EXT] = ext_irq;
  end

  reg [DATA_W-1:0] fifo_stat_d;
  always @* begin
    fifo_stat_d = {DATA_W{1'b0}};
    fifo_stat_d[`HP_STAT_TX_BUSY] = tx_valid;
    fifo_stat_d[`HP_STAT_RX_FULL] = rx_full_q;
  end

  // ****************************************
  // access tracking
  // ****************************************
  // rd_prev_q marks the first cycle of a read, so a receive pop happens
  // once per read however long the host holds the strobe
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_prev_q <= 1'b0;
      tx_valid_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_active;
      tx_valid_prev_q <= tx_valid;
    end
  end

  // ****************************************
  // config byte array
  // ****************************************
  // cleared by reset like every other register; the price is that the
  // array sits in flops instead of a ram macro
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < `HP_CFG_WORDS; i = i + 1) begin
        cfg_mem[i] <= `HP_BYTE_RST;
      end
    end else if (wr_pulse && in_cfg) begin
      cfg_mem[cfg_idx] <= host_data_bus_in;
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= `HP_BYTE_RST;
      irq_mask_q <= `HP_BYTE_RST;
    end else begin
      if (wr_pulse && is_addr(host_addr_bus, `HP_ADDR_IRQ_MASK)) begin
        irq_mask_q <= host_data_bus_in;
      end
      // write-one-to-clear; a new event in the same cycle stays set
      if (wr_pulse && is_addr(host_addr_bus, `HP_ADDR_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~host_data_bus_in) | irq_set_d;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set_d;
      end
    end
  end

  // ****************************************
  // packet data path
  // ****************************************
  // one-byte hand-off to the packet engine; a write while busy is dropped
  // rather than stalled, since the host has no wait line on this port
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_byte <= `HP_BYTE_RST;
      tx_valid <= 1'b0;
    end else if (wr_pulse && is_addr(host_addr_bus, `HP_ADDR_TX_FIFO) && !tx_valid) begin
      tx_byte <= host_data_bus_in;
      tx_valid <= 1'b1;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // a captured byte holds the engine off until read; capture beats a pop
  // in the same cycle, which can only meet an empty holder anyway
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_hold_q <= `HP_BYTE_RST;
      rx_full_q <= 1'b0;
    end else if (rx_take) begin
      rx_hold_q <= rx_byte;
      rx_full_q <= 1'b1;
    end else if (rx_pop) begin
      rx_full_q <= 1'b0;
    end
  end

  // ****************************************
  // read data and pins
  // ****************************************
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_data_bus_out <= `HP_BYTE_RST;
    end else if (in_cfg) begin
      host_data_bus_out <= cfg_mem[cfg_idx];
    end else if (is_addr(host_addr_bus, `HP_ADDR_IRQ_STAT)) begin
      host_data_bus_out <= irq_stat_q;
    end else if (is_addr(host_addr_bus, `HP_ADDR_IRQ_MASK)) begin
      host_data_bus_out <= irq_mask_q;
    end else if (is_addr(host_addr_bus, `HP_ADDR_TX_FIFO)) begin
      host_data_bus_out <= tx_byte;
    end else if (is_addr(host_addr_bus, `HP_ADDR_RX_FIFO)) begin
      host_data_bus_out <= rx_hold_q;
    end else if (is_addr(host_addr_bus, `HP_ADDR_FIFO_STAT)) begin
      host_data_bus_out <= fifo_stat_d;
    end else begin
      host_data_bus_out <= `HP_READ_UNMAPPED;
    end
  end

  // enable follows the synchronised read, data lags it by nothing extra
  // since the data register tracks the address every cycle
  assign host_data_bus_oe = rd_active;
  assign host_irq_n_out = 1'b0;
  assign host_irq_n_oe = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

// ===== host_port_checker.sv
/* checker for the host port pins and packet path.
   assumes it is bound to the port module at default widths. */
`timescale 1ns/1ps
`default_nettype none
module host_port_checker (
  // clock and reset
  input wire ref_clk, input wire nrst,
  // host pins
  input wire [8:0] host_addr_bus, input wire [7:0] host_data_bus_in,
  input wire host_select_n, input wire host_write_strobe_n, input wire host_read_strobe_n,
  input wire host_data_bus_oe, input wire host_irq_n_out, input wire host_irq_n_oe,
  // packet path
  input wire [7:0] tx_byte, input wire tx_valid, input wire tx_ready,
  input wire rx_valid, input wire rx_ready
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_pull; host_irq_n_out == 1'b0; endproperty
  a_pull: assert property (p_pull) else $error("irq pull level high");
  property p_desel; host_select_n [*3] |-> !host_data_bus_oe; endproperty
  a_desel: assert property (p_desel) else $error("bus driven unselected");
  property p_wfirst; !host_write_strobe_n [*3] |-> !host_data_bus_oe; endproperty
  a_wfirst: assert property (p_wfirst) else $error("bus driven in write");
  property p_rd;
    (!host_select_n && !host_read_strobe_n && host_write_strobe_n) [*3] |-> host_data_bus_oe;
  endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_wlat;
    $fell(host_write_strobe_n) && !host_select_n && host_addr_bus == 9'h102 && !tx_valid
      && !tx_ready |-> ##[1:4] (tx_valid && tx_byte == host_data_bus_in);
  endproperty
  a_wlat: assert property (p_wlat) else $error("write not stored");
  property p_once;
    $fell(tx_valid) && !host_write_strobe_n && !host_select_n |=> !tx_valid;
  endproperty
  a_once: assert property (p_once) else $error("held strobe wrote twice");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  a_hold: assert property (p_hold) else $error("tx byte dropped");
  property p_rxtake; rx_valid && rx_ready |=> !rx_ready; endproperty
  a_rxtake: assert property (p_rxtake) else $error("rx byte not held");
  c_rd: cover property (host_data_bus_oe);
  c_tx: cover property ($fell(tx_valid));
  c_irq: cover property ($rose(host_irq_n_oe));
endmodule
`default_nettype wire

// ===== host_mcu.sv
/* model of the microcontroller host on the port pins.
   assumes the bench calls acc from one process at a time. */
`timescale 1ns/1ps
`default_nettype none
module host_mcu (
  input wire ref_clk,
  input wire [7:0] host_data_bus_out, input wire host_data_bus_oe,
  output logic [8:0] host_addr_bus = 9'h000, output logic host_select_n = 1'b1,
  output logic host_write_strobe_n = 1'b1, output logic host_read_strobe_n = 1'b1,
  output wire [7:0] host_data_bus
);
  logic [7:0] drv_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic drv_en = 1'b0;
  // a released bus toggles so a stale byte can never pass for read data
  assign host_data_bus = host_data_bus_oe ? host_data_bus_out : drv_en ? drv_q : ~last_q;
  always @(posedge ref_clk) last_q <= host_data_bus;
  // address, data and strobes held n cycles, then data and strobes released together, address left in place
  task automatic acc(input logic s, input logic w, input logic r, input logic [8:0] a,
                     input logic [7:0] d, input int n, output logic [7:0] q);
    @(posedge ref_clk);
    host_addr_bus <= a;
    drv_q <= d;
    drv_en <= !w;
    host_select_n <= s;
    host_write_strobe_n <= w;
    host_read_strobe_n <= r;
    repeat (n) @(posedge ref_clk);
    q = host_data_bus;
    host_select_n <= 1'b1;
    host_write_strobe_n <= 1'b1;
    host_read_strobe_n <= 1'b1;
    drv_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ===== test_byte_host_register_port.sv
/* self-checking bench for the host port, host model on the pins.
   assumes the port module and host_mcu are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_byte_host_register_port;
  logic ref_clk = 1'b0, nrst = 1'b0, tx_ready = 1'b0, rx_valid = 1'b0, ext_irq = 1'b0;
  logic [7:0] rx_byte = 8'h00, q;
  wire [8:0] a;
  wire [7:0] d, dout, tx_byte;
  wire sel_n, wr_n, rd_n, oe, irq_out, irq_oe, tx_valid, rx_ready;
  int failures = 0, checks_done = 0;
  logic [16:0] rows [4] = '{{9'h000, 8'h5A}, {9'h0FF, 8'hA5}, {9'h080, 8'hFF}, {9'h001, 8'h81}};
  always #5 ref_clk = ~ref_clk;
  host_mcu mcu (.ref_clk(ref_clk), .host_data_bus_out(dout), .host_data_bus_oe(oe),
    .host_addr_bus(a), .host_select_n(sel_n), .host_write_strobe_n(wr_n),
    .host_read_strobe_n(rd_n), .host_data_bus(d));
  byte_host_register_port dut (.ref_clk(ref_clk), .nrst(nrst), .host_addr_bus(a),
    .host_data_bus_in(d), .host_data_bus_out(dout), .host_data_bus_oe(oe),
    .host_select_n(sel_n), .host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n),
    .host_irq_n_out(irq_out), .host_irq_n_oe(irq_oe), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .ext_irq(ext_irq));
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rx_push(input logic [7:0] b);
    @(posedge ref_clk);
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    @(posedge ref_clk);
    chk("rx_ready", 1'b0, rx_ready);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    chk("reset", 4'h1, {oe, irq_oe, tx_valid, rx_ready});
    nrst <= 1'b1;
    foreach (rows[i]) begin
      mcu.acc(0, 0, 1, rows[i][16:8], rows[i][7:0], 4, q);
      mcu.acc(0, 1, 0, rows[i][16:8], 8'h00, 4, q);
      chk("cfg", rows[i][7:0], q);
    end
    mcu.acc(0, 1, 0, 9'h000, 8'h00, 4, q);
    chk("cfg_keep", 8'h5A, q);
    mcu.acc(1, 0, 1, 9'h000, 8'hEE, 4, q);
    mcu.acc(0, 1, 0, 9'h000, 8'h00, 4, q);
    chk("deselected", 8'h5A, q);
    mcu.acc(0, 0, 0, 9'h001, 8'hC3, 4, q);
    mcu.acc(0, 1, 0, 9'h001, 8'h00, 4, q);
    chk("both_low", 8'hC3, q);
    mcu.acc(0, 0, 1, 9'h1FF, 8'h77, 4, q);
    mcu.acc(0, 1, 0, 9'h1FF, 8'h00, 4, q);
    chk("unmapped", 8'h00, q);
    fork
      mcu.acc(0, 0, 1, 9'h102, 8'h3C, 14, q);
      begin
        repeat (8) @(posedge ref_clk);
        chk("tx", 9'h13C, {tx_valid, tx_byte});
        tx_ready <= 1'b1;
      end
    join
    chk("tx_once", 1'b0, tx_valid);
    tx_ready <= 1'b0;
    mcu.acc(0, 0, 1, 9'h102, 8'h5A, 4, q);
    mcu.acc(0, 0, 1, 9'h102, 8'h99, 4, q);
    mcu.acc(0, 1, 0, 9'h104, 8'h00, 4, q);
    chk("tx_busy", 9'h15A, {tx_valid, tx_byte});
    chk("fifo_busy", 8'h01, q);
    tx_ready <= 1'b1;
    @(posedge ref_clk);
    tx_ready <= 1'b0;
    rx_push(8'h96);
    mcu.acc(0, 1, 0, 9'h103, 8'h00, 4, q);
    chk("rx", 9'h196, {rx_ready, q});
    mcu.acc(0, 0, 1, 9'h101, 8'h04, 4, q);
    chk("irq_masked", 1'b0, irq_oe);
    ext_irq <= 1'b1;
    @(posedge ref_clk);
    ext_irq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq", 2'h1, {irq_out, irq_oe});
    mcu.acc(0, 1, 0, 9'h100, 8'h00, 4, q);
    chk("irq_stat", 8'h07, q);
    mcu.acc(0, 0, 1, 9'h100, 8'h07, 4, q);
    chk("irq_clear", 1'b0, irq_oe);
    rx_push(8'h11);
    mcu.acc(0, 1, 0, 9'h104, 8'h00, 4, q);
    chk("fifo_full", 8'h02, q);
    mcu.acc(0, 1, 0, 9'h102, 8'h00, 4, q);
    chk("tx_read", 8'h5A, q);
    mcu.acc(0, 1, 0, 9'h101, 8'h00, 4, q);
    chk("mask_read", 8'h04, q);
    nrst <= 1'b0;
    #2 chk("async_reset", 1'b1, rx_ready);
    @(posedge ref_clk);
    nrst <= 1'b1;
    mcu.acc(0, 1, 0, 9'h0FF, 8'h00, 4, q);
    chk("cfg_reset", 8'h00, q);
    close_out();
  end
endmodule
bind byte_host_register_port host_port_checker chk_u (.ref_clk(ref_clk), .nrst(nrst),
  .host_addr_bus(host_addr_bus), .host_data_bus_in(host_data_bus_in),
  .host_select_n(host_select_n), .host_write_strobe_n(host_write_strobe_n),
  .host_read_strobe_n(host_read_strobe_n), .host_data_bus_oe(host_data_bus_oe),
  .host_irq_n_out(host_irq_n_out), .host_irq_n_oe(host_irq_n_oe), .tx_byte(tx_byte),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_ready(rx_ready));
`default_nettype wire
